// >>> prsc_regs.svh
`ifndef PRSC_REGS_SVH
`define PRSC_REGS_SVH
// register byte addresses
`define PRSC_ADDR_RST_ONE   32'h40001860
`define PRSC_ADDR_RST_TWO   32'h40001864
`define PRSC_ADDR_OSC       32'h40001884
`define PRSC_ADDR_LVIC      32'h40005100
`define PRSC_ADDR_LVRC      32'h40005104
`define PRSC_ADDR_IRQ_STAT  32'h40005108
`define PRSC_ADDR_IRQ_MASK  32'h4000510C
// implemented bits of the peripheral reset registers
`define PRSC_RST_ONE_MASK   32'h0040401D
`define PRSC_RST_TWO_MASK   32'h182C9C45
`define PRSC_RST_ONE_RESET  32'h00000000
`define PRSC_RST_TWO_RESET  32'h00000000
`define PRSC_FLASH_RST_BIT  19
// sub oscillator drive field
`define PRSC_OSC_LSB        3
`define PRSC_OSC_RESET      3'h7
// indicator control fields
`define PRSC_LVIC_EN_BIT    7
`define PRSC_LVIC_IEN_BIT   5
`define PRSC_LVIC_FLAG_BIT  4
`define PRSC_LVIC_THR_LSB   0
`define PRSC_LVIC_THR_RESET 3'h0
// low voltage reset enable field
`define PRSC_LVRC_OFF_KEY   8'h55
`define PRSC_LVRC_RESET     8'h00
// interrupt status and mask bits
`define PRSC_IRQ_IND_BIT    0
`define PRSC_IRQ_REFUSE_BIT 1
`define PRSC_IRQ_RESET      2'h0
// bus responses
`define PRSC_RESP_OKAY      2'h0
`define PRSC_RESP_SLVERR    2'h2
`endif

// >>> prsc_pkg.sv
`default_nettype none
package prsc_pkg;
  typedef logic [31:0] prsc_word_t;
  typedef logic [3:0]  prsc_strb_t;
  typedef enum logic [2:0] {
    PRSC_SEL_RST_ONE,
    PRSC_SEL_RST_TWO,
    PRSC_SEL_OSC,
    PRSC_SEL_LVIC,
    PRSC_SEL_LVRC,
    PRSC_SEL_IRQ_STAT,
    PRSC_SEL_IRQ_MASK,
    PRSC_SEL_NONE
  } prsc_sel_e;
endpackage : prsc_pkg
`default_nettype wire

// >>> prsc_ctrl.sv
// What this block does
// - timer and temp sensor reset bits set by writing one, cleared by software
// - port E, D, C, A reset bits at 4, 3, 2, 0, software clears
// - comparator reset bits 28 and 27, cleared by software
// - bit 21 holds second serial interface in reset until cleared
// - bit 19 resets flash controller; set refused while flash busy
// - bits 18 and 15 reset indicator and low power serial port
// - bits 12, 11, 10 reset checksum, calendar and converter
// - bits 6, 2, 0 reset two-wire, first uart, sync serial unit
// - all registers 32 bits, reachable by word, halfword and byte
// - drive field bits 5..3 resets to 111, codes steer current level
// - indicator control bit 7 enables indicator, resets to zero
// - bit 5 enables indicator irq, bit 4 flag set by hw, write one clears
// - bits 2..0 choose the indicator threshold voltage
// - reset enable field off only at 0x55, cleared only by power-on
// - set reset bit drives the peripheral reset line
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "prsc_regs.svh"
module prsc_ctrl (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire                    por_resetn,
  input  wire prsc_pkg::prsc_word_t s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire prsc_pkg::prsc_word_t s_axi_wdata,
  input  wire prsc_pkg::prsc_strb_t s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire prsc_pkg::prsc_word_t s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output logic                   s_axi_arready,
  output prsc_pkg::prsc_word_t   s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire                    flash_busy,
  input  wire                    indicator_detect,
  output prsc_pkg::prsc_word_t   periph_rst_one,
  output prsc_pkg::prsc_word_t   periph_rst_two,
  output logic [2:0]             sub_osc_drive_select,
  output logic                   voltage_indicator_on,
  output logic [2:0]             voltage_indicator_threshold,
  output logic                   undervoltage_reset_active,
  output logic                   irq
);
  import prsc_pkg::*;

  // register state
  logic [7:0] undervoltage_reset_enable;
  logic       voltage_indicator_irq_enable;
  logic       voltage_indicator_irq_flag;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // write channel holding registers
  logic       aw_full;
  logic       w_full;
  prsc_word_t aw_addr_q;
  prsc_word_t w_data_q;
  prsc_strb_t w_strb_q;
  logic       wr_commit;
  prsc_sel_e  wr_sel;
  prsc_word_t lane_mask;

  // address decode, shared by the read and write paths
  function automatic prsc_sel_e decode(input prsc_word_t addr);
    unique case (addr)
      `PRSC_ADDR_RST_ONE:  decode = PRSC_SEL_RST_ONE;
      `PRSC_ADDR_RST_TWO:  decode = PRSC_SEL_RST_TWO;
      `PRSC_ADDR_OSC:      decode = PRSC_SEL_OSC;
      `PRSC_ADDR_LVIC:     decode = PRSC_SEL_LVIC;
      `PRSC_ADDR_LVRC:     decode = PRSC_SEL_LVRC;
      `PRSC_ADDR_IRQ_STAT: decode = PRSC_SEL_IRQ_STAT;
      `PRSC_ADDR_IRQ_MASK: decode = PRSC_SEL_IRQ_MASK;
      default:             decode = PRSC_SEL_NONE;
    endcase
  endfunction : decode

  // keep old bits outside the written lanes
  function automatic prsc_word_t merge(input prsc_word_t old_v);
    merge = (old_v & ~lane_mask) | (w_data_q & lane_mask);
  endfunction : merge

  // byte strobes widened to a bit mask
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign lane_mask[gl*8 +: 8] = {8{w_strb_q[gl]}};
    end
  endgenerate

  // a write fires once both halves are held and no response is pending
  assign s_axi_awready = !aw_full;
  assign s_axi_wready  = !w_full;
  assign wr_commit     = aw_full && w_full && !s_axi_bvalid;
  assign wr_sel        = decode(aw_addr_q);

  // write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full   <= 1'b0;
      aw_addr_q <= 32'h00000000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full   <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_full <= 1'b0;
    end
  end

  // write data holding, either order against the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full   <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full   <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_full <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PRSC_RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == PRSC_SEL_NONE) ? `PRSC_RESP_SLVERR
                                                : `PRSC_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // first peripheral reset register; only listed bits are kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_rst_one <= `PRSC_RST_ONE_RESET;
    end else if (wr_commit && wr_sel == PRSC_SEL_RST_ONE) begin
      periph_rst_one <= merge(periph_rst_one) & `PRSC_RST_ONE_MASK;
    end
  end

  // busy flash: a set would corrupt the operation, so drop it; clears pass
  prsc_word_t next_rst_two;
  logic       flash_refused;
  always_comb begin
    next_rst_two  = merge(periph_rst_two) & `PRSC_RST_TWO_MASK;
    flash_refused = 1'b0;
    if (flash_busy && next_rst_two[`PRSC_FLASH_RST_BIT] &&
        !periph_rst_two[`PRSC_FLASH_RST_BIT]) begin
      next_rst_two[`PRSC_FLASH_RST_BIT] = 1'b0;
      flash_refused = wr_commit && wr_sel == PRSC_SEL_RST_TWO;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_rst_two <= `PRSC_RST_TWO_RESET;
    end else if (wr_commit && wr_sel == PRSC_SEL_RST_TWO) begin
      periph_rst_two <= next_rst_two;
    end
  end

  // sub oscillator drive; reserved codes are stored as written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_osc_drive_select <= `PRSC_OSC_RESET;
    end else if (wr_commit && wr_sel == PRSC_SEL_OSC && w_strb_q[0]) begin
      sub_osc_drive_select <= w_data_q[`PRSC_OSC_LSB +: 3];
    end
  end

  // indicator control fields, all in byte lane 0
  logic lvic_wr;
  assign lvic_wr = wr_commit && wr_sel == PRSC_SEL_LVIC && w_strb_q[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      voltage_indicator_on         <= 1'b0;
      voltage_indicator_irq_enable <= 1'b0;
      voltage_indicator_threshold  <= `PRSC_LVIC_THR_RESET;
    end else if (lvic_wr) begin
      voltage_indicator_on         <= w_data_q[`PRSC_LVIC_EN_BIT];
      voltage_indicator_irq_enable <= w_data_q[`PRSC_LVIC_IEN_BIT];
      voltage_indicator_threshold  <= w_data_q[`PRSC_LVIC_THR_LSB +: 3];
    end
  end

  // indicator flag: a request in the clearing cycle still sets it
  logic indicator_event;
  assign indicator_event = voltage_indicator_on && indicator_detect;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      voltage_indicator_irq_flag <= 1'b0;
    end else if (indicator_event) begin
      voltage_indicator_irq_flag <= 1'b1;
    end else if (lvic_wr && w_data_q[`PRSC_LVIC_FLAG_BIT]) begin
      voltage_indicator_irq_flag <= 1'b0;
    end
  end

  // reset enable survives system reset; only power-on clears it
  always_ff @(posedge aclk) begin
    if (!por_resetn) begin
      undervoltage_reset_enable <= `PRSC_LVRC_RESET;
    end else if (wr_commit && wr_sel == PRSC_SEL_LVRC && w_strb_q[0]) begin
      undervoltage_reset_enable <= w_data_q[7:0];
    end
  end
  assign undervoltage_reset_active =
    undervoltage_reset_enable != `PRSC_LVRC_OFF_KEY;

  // sticky event status, write one to clear, set wins
  logic [1:0] irq_events;
  assign irq_events = {flash_refused,
                       indicator_event && voltage_indicator_irq_enable};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `PRSC_IRQ_RESET;
    end else if (wr_commit && wr_sel == PRSC_SEL_IRQ_STAT && w_strb_q[0]) begin
      irq_status <= (irq_status & ~w_data_q[1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  // interrupt mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `PRSC_IRQ_RESET;
    end else if (wr_commit && wr_sel == PRSC_SEL_IRQ_MASK && w_strb_q[0]) begin
      irq_mask <= w_data_q[1:0];
    end
  end

  // level interrupt from unmasked sticky status bits only
  assign irq = |(irq_status & irq_mask);

  // read data assembly; reserved bits come back zero
  function automatic prsc_word_t read_word(input prsc_sel_e sel);
    read_word = 32'h00000000;
    unique case (sel)
      PRSC_SEL_RST_ONE:  read_word = periph_rst_one;
      PRSC_SEL_RST_TWO:  read_word = periph_rst_two;
      PRSC_SEL_OSC:
        read_word[`PRSC_OSC_LSB +: 3] = sub_osc_drive_select;
      PRSC_SEL_LVIC: begin
        read_word[`PRSC_LVIC_EN_BIT]     = voltage_indicator_on;
        read_word[`PRSC_LVIC_IEN_BIT]    = voltage_indicator_irq_enable;
        read_word[`PRSC_LVIC_FLAG_BIT]   = voltage_indicator_irq_flag;
        read_word[`PRSC_LVIC_THR_LSB +: 3] = voltage_indicator_threshold;
      end
      PRSC_SEL_LVRC:     read_word[7:0] = undervoltage_reset_enable;
      PRSC_SEL_IRQ_STAT: read_word[1:0] = irq_status;
      PRSC_SEL_IRQ_MASK: read_word[1:0] = irq_mask;
      PRSC_SEL_NONE:     read_word = 32'h00000000;
    endcase
  endfunction : read_word

  // read channel; one read in flight, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `PRSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_word(decode(s_axi_araddr));
      s_axi_rresp  <= (decode(s_axi_araddr) == PRSC_SEL_NONE) ?
                      `PRSC_RESP_SLVERR : `PRSC_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic c1, c2;
  assign c1 = wr_commit && wr_sel == PRSC_SEL_RST_ONE;
  assign c2 = wr_commit && wr_sel == PRSC_SEL_RST_TWO;
  property p_rst_one_set;
    c1 && w_strb_q[2] && w_data_q[22] |=> periph_rst_one[22];
  endproperty
  a_rst_one_set: assert property (p_rst_one_set)
    else $error("timer reset bit not set");
  property p_port_clear;
    c1 && w_strb_q[0] && !w_data_q[0] |=> !periph_rst_one[0];
  endproperty
  a_port_clear: assert property (p_port_clear)
    else $error("port a reset bit not cleared");
  property p_cmp_set;
    c2 && w_strb_q[3] && w_data_q[28] |=> periph_rst_two[28];
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("comparator reset bit not set");
  property p_spi_set;
    c2 && w_strb_q[2] && w_data_q[21] |=> periph_rst_two[21];
  endproperty
  a_spi_set: assert property (p_spi_set)
    else $error("serial reset bit not set");

  property p_flash_refuse;
    c2 && flash_busy && !periph_rst_two[19] |=> !periph_rst_two[19];
  endproperty
  a_flash_refuse: assert property (p_flash_refuse)
    else $error("flash reset taken while busy");

  property p_full_word;
    c2 && w_strb_q == 4'hF && !flash_busy |=>
      periph_rst_two == ($past(w_data_q) & `PRSC_RST_TWO_MASK);
  endproperty
  a_full_word: assert property (p_full_word)
    else $error("word write to reset two mismatch");

  property p_lane_keep;
    c2 && !w_strb_q[1] |=> periph_rst_two[15] == $past(periph_rst_two[15]);
  endproperty
  a_lane_keep: assert property (p_lane_keep)
    else $error("unwritten lane changed");

  property p_low_clear;
    c2 && w_strb_q[0] && w_data_q[7:0] == 8'h00 |=>
      !periph_rst_two[6] && !periph_rst_two[2] && !periph_rst_two[0];
  endproperty
  a_low_clear: assert property (p_low_clear)
    else $error("low reset bits not cleared");

  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered next cycle");

  property p_osc_reset;
    $rose(aresetn) |-> sub_osc_drive_select == 3'h7;
  endproperty
  a_osc_reset: assert property (p_osc_reset)
    else $error("drive field reset value wrong");

  property p_flag_set;
    voltage_indicator_on && indicator_detect |=> voltage_indicator_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("indicator flag lost");

  property p_flag_off;
    !voltage_indicator_on && !voltage_indicator_irq_flag |=>
      !voltage_indicator_irq_flag;
  endproperty
  a_flag_off: assert property (p_flag_off)
    else $error("flag set while indicator off");

  property p_threshold;
    lvic_wr |=> voltage_indicator_threshold == $past(w_data_q[2:0]);
  endproperty
  a_threshold: assert property (p_threshold)
    else $error("threshold not written");

  property p_lvr_por;
    !por_resetn |=> undervoltage_reset_active;
  endproperty
  a_lvr_por: assert property (p_lvr_por)
    else $error("reset enable not cleared by power-on");

  property p_hold;
    !wr_commit |=> $stable(periph_rst_one) && $stable(periph_rst_two);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset bit changed without write");

  property p_reserved;
    (periph_rst_one & ~`PRSC_RST_ONE_MASK) == 32'h00000000 &&
    (periph_rst_two & ~`PRSC_RST_TWO_MASK) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");

  c_flash_refused: cover property (flash_refused);
  c_flag_irq: cover property (irq_status[`PRSC_IRQ_IND_BIT] && irq);
  c_lvr_off: cover property (!undervoltage_reset_active);
  c_partial: cover property (c2 && w_strb_q == 4'h4);
endmodule : prsc_ctrl
`default_nettype wire

// >>> prsc_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "prsc_regs.svh"
module prsc_ctrl_test;
  import prsc_pkg::*;
  logic       aclk, aresetn, por_resetn, flash_busy, indicator_detect;
  logic       awvalid, awready, wvalid, wready, bvalid, bready;
  logic       arvalid, arready, rvalid, rready, lv_on, uv_act, irq;
  logic [1:0] bresp, rresp, br;
  logic [2:0] drive, thr;
  prsc_word_t awaddr, wdata, araddr, rdata, rst_one, rst_two, rd;
  prsc_strb_t wstrb;
  int         fail_count = 0;
  int         tests_run = 0;
  int         cyc = 0;

  prsc_ctrl i_dut (
    .aclk(aclk), .aresetn(aresetn), .por_resetn(por_resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_busy(flash_busy), .indicator_detect(indicator_detect),
    .periph_rst_one(rst_one), .periph_rst_two(rst_two),
    .sub_osc_drive_select(drive), .voltage_indicator_on(lv_on),
    .voltage_indicator_threshold(thr),
    .undervoltage_reset_active(uv_act), .irq(irq)
  );

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic results;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input string n, input prsc_word_t seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, exp, seen);
    end
  endtask : check

  // leading edge keeps a strobe from being set twice in one time step
  task automatic wr(input prsc_word_t a, d, input prsc_strb_t s);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        br = bresp;
        break;
      end
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rdr(input prsc_word_t a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        br = rresp;
        break;
      end
    end
    rready <= 1'b0;
  endtask : rdr

  task automatic rchk(input prsc_word_t a, exp, input string n);
    rdr(a);
    check(n, rd, exp);
  endtask : rchk

  task automatic t_reset;
    rchk(`PRSC_ADDR_RST_ONE, 32'h0, "rst_one");
    rchk(`PRSC_ADDR_RST_TWO, 32'h0, "rst_two");
    rchk(`PRSC_ADDR_OSC, 32'h00000038, "osc");
    rchk(`PRSC_ADDR_LVIC, 32'h0, "lvic");
    rchk(`PRSC_ADDR_LVRC, 32'h0, "lvrc");
    check("uv_act", 32'(uv_act), 32'h1);
    check("irq", 32'(irq), 32'h0);
  endtask : t_reset

  task automatic t_rst_one;
    wr(`PRSC_ADDR_RST_ONE, 32'hFFFFFFFF, 4'hF);
    check("bresp", 32'(br), 32'h0);
    rchk(`PRSC_ADDR_RST_ONE, 32'h0040401D, "one");
    check("one_pins", rst_one, 32'h0040401D);
    wr(`PRSC_ADDR_RST_ONE, 32'h0, 4'h1);
    rchk(`PRSC_ADDR_RST_ONE, 32'h00404000, "one_b0");
    check("one_pins", rst_one, 32'h00404000);
    wr(`PRSC_ADDR_RST_ONE, 32'h0, 4'hF);
    check("one_pins", rst_one, 32'h0);
  endtask : t_rst_one

  task automatic t_rst_two;
    wr(`PRSC_ADDR_RST_TWO, 32'hFFFFFFFF, 4'hF);
    rchk(`PRSC_ADDR_RST_TWO, 32'h182C9C45, "two");
    check("two_pins", rst_two, 32'h182C9C45);
    wr(`PRSC_ADDR_RST_TWO, 32'h0, 4'hC);
    rchk(`PRSC_ADDR_RST_TWO, 32'h00009C45, "two_hw");
    wr(`PRSC_ADDR_RST_TWO, 32'h0, 4'hF);
    check("two_pins", rst_two, 32'h0);
  endtask : t_rst_two

  // set request during a flash operation is dropped and flagged
  task automatic t_flash;
    flash_busy <= 1'b1;
    wr(`PRSC_ADDR_RST_TWO, 32'h00080000, 4'hF);
    check("two_busy", rst_two, 32'h0);
    rchk(`PRSC_ADDR_IRQ_STAT, 32'h2, "stat");
    wr(`PRSC_ADDR_IRQ_MASK, 32'h2, 4'hF);
    check("irq", 32'(irq), 32'h1);
    wr(`PRSC_ADDR_IRQ_STAT, 32'h2, 4'h1);
    check("irq", 32'(irq), 32'h0);
    flash_busy <= 1'b0;
    wr(`PRSC_ADDR_RST_TWO, 32'h00080000, 4'hF);
    check("two_idle", rst_two, 32'h00080000);
    flash_busy <= 1'b1;
    wr(`PRSC_ADDR_RST_TWO, 32'h0, 4'hF);
    check("two_rel", rst_two, 32'h0);
    flash_busy <= 1'b0;
  endtask : t_flash

  task automatic t_osc;
    for (int c = 0; c < 8; c++) begin
      wr(`PRSC_ADDR_OSC, 32'(c) << 3, 4'hF);
      check("drive", 32'(drive), 32'(c));
    end
    wr(`PRSC_ADDR_OSC, 32'h000000FF, 4'h1);
    rchk(`PRSC_ADDR_OSC, 32'h00000038, "osc");
  endtask : t_osc

  task automatic t_indicator;
    for (int c = 0; c < 8; c++) begin
      wr(`PRSC_ADDR_LVIC, 32'(c), 4'h1);
      check("thr", 32'(thr), 32'(c));
    end
    wr(`PRSC_ADDR_LVIC, 32'h000000FF, 4'h1);
    rchk(`PRSC_ADDR_LVIC, 32'h000000A7, "lvic");
    check("lv_on", 32'(lv_on), 32'h1);
    @(posedge aclk);
    indicator_detect <= 1'b1;
    @(posedge aclk);
    indicator_detect <= 1'b0;
    rchk(`PRSC_ADDR_LVIC, 32'h000000B7, "flag");
    // status bit0 is set but still masked off, so no interrupt yet
    check("irq", 32'(irq), 32'h0);
    rchk(`PRSC_ADDR_IRQ_STAT, 32'h1, "stat");
    // flag cleared by one; status bit0 still set but masked
    wr(`PRSC_ADDR_LVIC, 32'h000000B7, 4'h1);
    rchk(`PRSC_ADDR_LVIC, 32'h000000A7, "w1c");
    check("irq", 32'(irq), 32'h0);
    wr(`PRSC_ADDR_IRQ_MASK, 32'h1, 4'hF);
    check("irq", 32'(irq), 32'h1);
    wr(`PRSC_ADDR_IRQ_STAT, 32'h1, 4'hF);
    check("irq", 32'(irq), 32'h0);
    wr(`PRSC_ADDR_LVIC, 32'h00000020, 4'h1);
    @(posedge aclk);
    indicator_detect <= 1'b1;
    @(posedge aclk);
    indicator_detect <= 1'b0;
    rchk(`PRSC_ADDR_LVIC, 32'h00000020, "off");
  endtask : t_indicator

  // system reset must spare the key, power-on reset must clear it
  task automatic t_undervolt;
    wr(`PRSC_ADDR_LVRC, 32'h00000055, 4'h1);
    rchk(`PRSC_ADDR_LVRC, 32'h00000055, "lvrc");
    check("uv_act", 32'(uv_act), 32'h0);
    wr(`PRSC_ADDR_LVRC, 32'h00000054, 4'h1);
    check("uv_act", 32'(uv_act), 32'h1);
    wr(`PRSC_ADDR_LVRC, 32'h00000055, 4'h1);
    wr(`PRSC_ADDR_RST_ONE, 32'h1, 4'hF);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("one_pins", rst_one, 32'h0);
    rchk(`PRSC_ADDR_LVRC, 32'h00000055, "keep");
    check("uv_act", 32'(uv_act), 32'h0);
    @(posedge aclk);
    por_resetn <= 1'b0;
    @(posedge aclk);
    por_resetn <= 1'b1;
    rchk(`PRSC_ADDR_LVRC, 32'h0, "por");
    check("uv_act", 32'(uv_act), 32'h1);
  endtask : t_undervolt

  task automatic t_unmapped;
    wr(32'h40001868, 32'hFFFFFFFF, 4'hF);
    check("bresp", 32'(br), 32'h2);
    rchk(32'h40001868, 32'h0, "rdata");
    check("rresp", 32'(br), 32'h2);
  endtask : t_unmapped

  // main sequence
  initial begin
    aresetn = 1'b0;
    por_resetn = 1'b0;
    flash_busy = 1'b0;
    indicator_detect = 1'b0;
    awaddr = '0;
    wdata = '0;
    wstrb = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    por_resetn <= 1'b1;
    t_reset();
    t_rst_one();
    t_rst_two();
    t_flash();
    t_osc();
    t_indicator();
    t_undervolt();
    t_unmapped();
    results();
  end
endmodule : prsc_ctrl_test
`default_nettype wire
